// File: rtl/lfg_cerr_cnt.sv
/*
  Correctable error counter with programmable threshold.
  Assumes error pulses and clear come from the core clock domain.
*/
`default_nettype none
module lfg_cerr_cnt
  import lfg_pkg::*;
#(
  parameter int W = lfg_pkg::CERR_CNT_W
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic err,
  input wire logic clr,
  input wire logic [W-1:0] thresh,
  output logic hit
);
  import lfg_pkg::*;
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (err && !(&cnt_reg))
      cnt_reg <= cnt_reg + 1'b1;
    else if (clr && !err)
      cnt_reg <= '0;
  end

  assign hit = cnt_reg >= thresh;
endmodule : lfg_cerr_cnt
`default_nettype wire

// File: rtl/lfg_guard.sv
/*
  Fence, bus barrier, imprecise bus error capture and access guard
  for the load/store unit. Assumes pipeline status inputs are on CLK;
  the external NMI pin comes from outside and is synchronised here.
*/
// Functional notes
// - Every data fence treated as full fence
// - Fence waits empty pipe, then drained buffers
// - Commit only when idle and bus quiet
// - Eight-bit outstanding transaction counter
// - Block requests while 255 outstanding
// - Barrier done only at zero count
// - Instruction fence also orders prior writes
// - First imprecise error logs address, raises NMI
// - Later errors ignored while capture is locked
// - Capture lock cleared by reset or unlock
// - Bus NMI held until reset, external passes
// - Store NMI F0000000, load NMI F0000001
// - Load error wins simultaneous store error
// - Eight instruction and eight data windows
// - Unmatched fetch faults, no bus access
// - No enabled windows disables protection
// - Unmatched load/store raises precise fault
// - Window: enable, 64B base, size mask
// - Precise fault address to mtval
// - Three correctable counters with thresholds
// - Correctable interrupt bit 30, cause 8000001E
// - Local regions must contain accesses wholly
`default_nettype none
module lfg_guard
  import lfg_pkg::*;
#(
  parameter logic [NUM_WIN-1:0] I_WIN_EN = '0,
  parameter logic [NUM_WIN*32-1:0] I_WIN_BASE = '0,
  parameter logic [NUM_WIN*32-1:0] I_WIN_MASK = '0,
  parameter logic [NUM_WIN-1:0] D_WIN_EN = '0,
  parameter logic [NUM_WIN*32-1:0] D_WIN_BASE = '0,
  parameter logic [NUM_WIN*32-1:0] D_WIN_MASK = '0
)
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic FENCE_REQ,
  input wire logic FENCE_I_REQ,
  input wire logic LSU_PIPE_EMPTY,
  input wire logic RD_BUF_CLEAR,
  input wire logic ST_BUF_EMPTY,
  input wire logic WR_BUF_EMPTY,
  output logic FENCE_STALL,
  output logic FENCE_DONE,
  output logic ICACHE_FLUSH,
  input wire logic BUS_REQ_IN,
  output logic BUS_REQ_OK,
  input wire logic BUS_RSP,
  output logic [7:0] OUTST_CNT,
  output logic BARRIER_DONE,
  input wire logic ST_ERR,
  input wire logic [31:0] ST_ERR_ADDR,
  input wire logic LD_ERR,
  input wire logic [31:0] LD_ERR_ADDR,
  input wire logic ERR_UNLOCK,
  input wire logic EXT_NMI,
  output logic NMI_REQ,
  output logic [31:0] NMI_MCAUSE,
  output logic [31:0] ERR_CAPT_ADDR,
  output logic ERR_LOCKED,
  input wire logic FETCH_VALID,
  input wire logic [31:0] FETCH_ADDR,
  input wire logic [31:0] FETCH_LAST,
  output logic FETCH_FAULT,
  output logic FETCH_TO_BUS,
  input wire logic LS_VALID,
  input wire logic [31:0] LS_ADDR,
  input wire logic [31:0] LS_LAST,
  output logic LS_FAULT,
  output logic LS_TO_BUS,
  output logic [31:0] MTVAL,
  input wire logic [2:0] CERR_EVT,
  input wire logic [2:0] CERR_CLR,
  input wire logic [3*CERR_CNT_W-1:0] CERR_THRESH,
  input wire logic CORR_INT_EN,
  output logic CORR_INT_PEND,
  output logic [31:0] CORR_MCAUSE
);
  import lfg_pkg::*;

  lfg_fence_e fence_state_reg;
  lfg_fence_e fence_state_next;
  logic [OUTST_W-1:0] outst_reg;
  logic [OUTST_W-1:0] outst_next;
  logic lock_reg;
  logic [2:0] nmi_sync_reg;
  logic ext_nmi_lvl_reg;
  logic [2:0] cerr_hit;
  logic i_fault;
  logic i_local;
  logic d_fault;
  logic d_local;
  logic req_fire;
  logic drained;

  assign req_fire = BUS_REQ_IN && (outst_reg != OUTST_MAX);
  assign drained = RD_BUF_CLEAR && ST_BUF_EMPTY && WR_BUF_EMPTY && (outst_reg == OUTST_ZERO);

  always_comb
  begin
    outst_next = outst_reg;
    if (req_fire && !BUS_RSP)
      outst_next = outst_reg + 8'h01;
    else if (!req_fire && BUS_RSP && (outst_reg != OUTST_ZERO))
      outst_next = outst_reg - 8'h01;
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      outst_reg <= OUTST_ZERO;
    else
      outst_reg <= outst_next;
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      OUTST_CNT <= OUTST_ZERO;
      BUS_REQ_OK <= 1'b0;
      BARRIER_DONE <= 1'b1;
    end
    else
    begin
      OUTST_CNT <= outst_next;
      BUS_REQ_OK <= outst_next != OUTST_MAX;
      BARRIER_DONE <= outst_next == OUTST_ZERO;
    end
  end

  always_comb
  begin
    fence_state_next = fence_state_reg;
    case (fence_state_reg)
      FNC_IDLE:
        if (FENCE_REQ || FENCE_I_REQ)
          fence_state_next = FNC_PRESYNC;
      FNC_PRESYNC:
        if (LSU_PIPE_EMPTY)
          fence_state_next = FNC_DRAIN;
      FNC_DRAIN:
        if (drained)
          fence_state_next = FNC_COMMIT;
      FNC_COMMIT:
        fence_state_next = FNC_IDLE;
      default:
        fence_state_next = FNC_IDLE;
    endcase
  end

  logic fence_i_reg;

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      fence_state_reg <= FNC_IDLE;
      fence_i_reg <= 1'b0;
    end
    else
    begin
      fence_state_reg <= fence_state_next;
      if (fence_state_reg == FNC_IDLE)
        fence_i_reg <= FENCE_I_REQ;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      FENCE_STALL <= 1'b0;
      FENCE_DONE <= 1'b0;
      ICACHE_FLUSH <= 1'b0;
    end
    else
    begin
      FENCE_STALL <= (fence_state_next == FNC_PRESYNC) || (fence_state_next == FNC_DRAIN);
      FENCE_DONE <= fence_state_next == FNC_COMMIT;
      ICACHE_FLUSH <= (fence_state_next == FNC_COMMIT) && fence_i_reg;
    end
  end

  // External NMI pin sync; only stages two and three are compared
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      nmi_sync_reg <= 3'b000;
      ext_nmi_lvl_reg <= 1'b0;
    end
    else
    begin
      nmi_sync_reg <= {nmi_sync_reg[1:0], EXT_NMI};
      if (nmi_sync_reg[1] == nmi_sync_reg[2])
        ext_nmi_lvl_reg <= nmi_sync_reg[2];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      lock_reg <= 1'b0;
      ERR_CAPT_ADDR <= ADDR_RST;
      NMI_MCAUSE <= MCAUSE_STORE_ERR;
    end
    else if (!lock_reg && (LD_ERR || ST_ERR))
    begin
      lock_reg <= 1'b1;
      if (LD_ERR)
      begin
        ERR_CAPT_ADDR <= LD_ERR_ADDR;
        NMI_MCAUSE <= MCAUSE_LOAD_ERR;
      end
      else
      begin
        ERR_CAPT_ADDR <= ST_ERR_ADDR;
        NMI_MCAUSE <= MCAUSE_STORE_ERR;
      end
    end
    else if (ERR_UNLOCK && !(LD_ERR || ST_ERR))
      lock_reg <= 1'b0;
  end

  logic bus_nmi_reg;

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      bus_nmi_reg <= 1'b0;
      NMI_REQ <= 1'b0;
      ERR_LOCKED <= 1'b0;
    end
    else
    begin
      if (!lock_reg && (LD_ERR || ST_ERR))
        bus_nmi_reg <= 1'b1;
      NMI_REQ <= bus_nmi_reg || ext_nmi_lvl_reg;
      ERR_LOCKED <= LD_ERR || ST_ERR || (lock_reg && !ERR_UNLOCK);
    end
  end

  lfg_win_check #(
    .NW(NUM_WIN),
    .WIN_EN(I_WIN_EN),
    .WIN_BASE(I_WIN_BASE),
    .WIN_MASK(I_WIN_MASK)
  ) u_iwin (
    .addr_first(FETCH_ADDR),
    .addr_last(FETCH_LAST),
    .fault(i_fault),
    .is_local(i_local)
  );

  lfg_win_check #(
    .NW(NUM_WIN),
    .WIN_EN(D_WIN_EN),
    .WIN_BASE(D_WIN_BASE),
    .WIN_MASK(D_WIN_MASK),
    .LOC2_EN(1'b1)
  ) u_dwin (
    .addr_first(LS_ADDR),
    .addr_last(LS_LAST),
    .fault(d_fault),
    .is_local(d_local)
  );

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      FETCH_FAULT <= 1'b0;
      FETCH_TO_BUS <= 1'b0;
      LS_FAULT <= 1'b0;
      LS_TO_BUS <= 1'b0;
    end
    else
    begin
      FETCH_FAULT <= FETCH_VALID && i_fault;
      FETCH_TO_BUS <= FETCH_VALID && !i_fault && !i_local;
      LS_FAULT <= LS_VALID && d_fault;
      LS_TO_BUS <= LS_VALID && !d_fault && !d_local;
    end
  end

  // precise fault address to mtval, load/store first
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      MTVAL <= ADDR_RST;
    else if (LS_VALID && d_fault)
      MTVAL <= LS_ADDR;
    else if (FETCH_VALID && i_fault)
      MTVAL <= FETCH_ADDR;
  end

  genvar ci;
  generate
    for (ci = 0; ci < 3; ci++)
    begin : g_cerr
      lfg_cerr_cnt #(
        .W(CERR_CNT_W)
      ) u_cnt (
        .clk(CLK),
        .rst(SYS_RST),
        .err(CERR_EVT[ci]),
        .clr(CERR_CLR[ci]),
        .thresh(CERR_THRESH[ci*CERR_CNT_W +: CERR_CNT_W]),
        .hit(cerr_hit[ci])
      );
    end
  endgenerate

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      CORR_INT_PEND <= 1'b0;
      CORR_MCAUSE <= MCAUSE_CORR_ERR;
    end
    else
    begin
      CORR_INT_PEND <= (|cerr_hit) && CORR_INT_EN;
      CORR_MCAUSE <= MCAUSE_CORR_ERR;
    end
  end
endmodule : lfg_guard
`default_nettype wire

// File: rtl/lfg_pkg.sv
/*
  Shared constants for the load/store fence, barrier and access guard.
  Assumes a 32-bit address space split into sixteen 256MB regions.
*/
`default_nettype none
package lfg_pkg;
  localparam int ADDR_W = 32;
  localparam int OUTST_W = 8;
  localparam logic [7:0] OUTST_MAX = 8'hFF;
  localparam logic [7:0] OUTST_ZERO = 8'h00;
  localparam int NUM_WIN = 8;
  localparam int WIN_ALIGN_LSB = 6;
  localparam int REGION_MSB = 31;
  localparam int REGION_LSB = 28;
  localparam logic [31:0] MCAUSE_STORE_ERR = 32'hF000_0000;
  localparam logic [31:0] MCAUSE_LOAD_ERR = 32'hF000_0001;
  localparam logic [31:0] MCAUSE_CORR_ERR = 32'h8000_001E;
  localparam int CORR_INT_BIT = 30;
  localparam int CERR_CNT_W = 16;
  localparam logic [15:0] CERR_CNT_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  typedef enum logic [1:0]
  {
    FNC_IDLE = 2'b00,
    FNC_PRESYNC = 2'b01,
    FNC_DRAIN = 2'b10,
    FNC_COMMIT = 2'b11
  } lfg_fence_e;
endpackage : lfg_pkg
`default_nettype wire

// File: rtl/lfg_win_check.sv
/*
  Access window checker and core-local region checker for one access side.
  Assumes window settings are static build-time values.
*/
`default_nettype none
module lfg_win_check
  import lfg_pkg::*;
#(
  parameter int NW = lfg_pkg::NUM_WIN,
  parameter logic [NW-1:0] WIN_EN = '0,
  parameter logic [NW*32-1:0] WIN_BASE = '0,
  parameter logic [NW*32-1:0] WIN_MASK = '0,
  parameter logic [3:0] LOC_REGION = 4'hF,
  parameter logic [31:0] LOC_BASE = 32'hF000_0000,
  parameter logic [31:0] LOC_MASK = 32'h0000_FFFF,
  parameter logic LOC2_EN = 1'b0,
  parameter logic [31:0] LOC2_BASE = 32'hF00C_0000,
  parameter logic [31:0] LOC2_MASK = 32'h0000_7FFF
)
(
  input wire logic [31:0] addr_first,
  input wire logic [31:0] addr_last,
  output logic fault,
  output logic is_local
);
  import lfg_pkg::*;
  logic [NW-1:0] hit;
  logic any_en;
  logic in1_f;
  logic in1_l;
  logic in2_f;
  logic in2_l;
  logic loc_region;

  genvar gi;
  generate
    for (gi = 0; gi < NW; gi++)
    begin : g_win
      assign hit[gi] = WIN_EN[gi] &&
        (((addr_first ^ WIN_BASE[gi*32 +: 32]) & ~WIN_MASK[gi*32 +: 32]) == 32'h0000_0000) &&
        (((addr_last ^ WIN_BASE[gi*32 +: 32]) & ~WIN_MASK[gi*32 +: 32]) == 32'h0000_0000);
    end
  endgenerate

  assign in1_f = ((addr_first ^ LOC_BASE) & ~LOC_MASK) == 32'h0000_0000;
  assign in1_l = ((addr_last ^ LOC_BASE) & ~LOC_MASK) == 32'h0000_0000;
  assign in2_f = LOC2_EN && (((addr_first ^ LOC2_BASE) & ~LOC2_MASK) == 32'h0000_0000);
  assign in2_l = LOC2_EN && (((addr_last ^ LOC2_BASE) & ~LOC2_MASK) == 32'h0000_0000);
  assign loc_region = addr_first[REGION_MSB:REGION_LSB] == LOC_REGION;
  // protection off when no window enabled
  assign any_en = |WIN_EN;

  always_comb
  begin
    is_local = loc_region;
    // local region must hold access wholly
    if (loc_region)
      fault = !((in1_f && in1_l) || (in2_f && in2_l));
    else
      fault = any_en && !(|hit);
  end
endmodule : lfg_win_check
`default_nettype wire

// File: verification/lfg_bus_model.sv
/*
  System bus far side: one response per accepted request.
  Assumes acceptance is request while the count is below max.
*/
`default_nettype none
module lfg_bus_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic acc_ok,
  input wire logic hold,
  output logic rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] pend_reg;
  logic [8:0] pend_next;
  // Never answers more than was issued
  assign pend_next = pend_reg + 9'(req && acc_ok) - 9'(rsp);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend_reg <= '0;
      rsp <= 1'b0;
    end
    else
    begin
      pend_reg <= pend_next;
      rsp <= !hold && pend_next != 9'h000;
    end
  end
endmodule : lfg_bus_model
`default_nettype wire

// File: verification/lfg_guard_chk.sv
/*
  Checker for lfg_guard: counter, fence and error capture.
  Bound to every lfg_guard instance.
*/
`default_nettype none
module lfg_guard_chk
  import lfg_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic FENCE_REQ,
  input wire logic FENCE_STALL,
  input wire logic FENCE_DONE,
  input wire logic ICACHE_FLUSH,
  input wire logic RD_BUF_CLEAR,
  input wire logic ST_BUF_EMPTY,
  input wire logic WR_BUF_EMPTY,
  input wire logic BUS_REQ_IN,
  input wire logic BUS_RSP,
  input wire logic [7:0] OUTST_CNT,
  input wire logic BARRIER_DONE,
  input wire logic ST_ERR,
  input wire logic LD_ERR,
  input wire logic [31:0] LD_ERR_ADDR,
  input wire logic ERR_UNLOCK,
  input wire logic NMI_REQ,
  input wire logic [31:0] NMI_MCAUSE,
  input wire logic [31:0] ERR_CAPT_ADDR,
  input wire logic ERR_LOCKED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic drained_q;
  logic drained_q2;
  // Two stages: commit may follow the sampled drain by one or two edges
  always_ff @(posedge CLK)
  begin
    drained_q <= RD_BUF_CLEAR && ST_BUF_EMPTY && WR_BUF_EMPTY && BARRIER_DONE;
    drained_q2 <= drained_q;
  end
  cnt_up_a: assert property (
    BUS_REQ_IN && OUTST_CNT != OUTST_MAX && !BUS_RSP |=> OUTST_CNT == $past(OUTST_CNT) + 8'h01)
    else $error("count did not rise");
  cnt_cap_a: assert property (
    OUTST_CNT == OUTST_MAX && !BUS_RSP |=> OUTST_CNT == OUTST_MAX) else $error("count passed max");
  barrier_zero_a: assert property (
    BARRIER_DONE == (OUTST_CNT == OUTST_ZERO)) else $error("barrier flag wrong");
  fence_stall_a: assert property (
    FENCE_REQ && !FENCE_STALL && !FENCE_DONE |=> FENCE_STALL) else $error("fence not stalled");
  fence_commit_a: assert property (
    FENCE_DONE |-> drained_q || drained_q2) else $error("fence done early");
  flush_done_a: assert property (
    ICACHE_FLUSH |-> FENCE_DONE) else $error("flush without commit");
  err_nmi_a: assert property (
    (LD_ERR || ST_ERR) && !ERR_LOCKED |=> ERR_LOCKED ##1 NMI_REQ) else $error("no lock or nmi");
  load_wins_a: assert property (
    LD_ERR && !ERR_LOCKED |=> NMI_MCAUSE == MCAUSE_LOAD_ERR && ERR_CAPT_ADDR == $past(LD_ERR_ADDR))
    else $error("load error lost");
  store_cause_a: assert property (
    ST_ERR && !LD_ERR && !ERR_LOCKED |=> NMI_MCAUSE == MCAUSE_STORE_ERR) else $error("bad cause");
  lock_hold_a: assert property (
    ERR_LOCKED && !ERR_UNLOCK |=> ERR_LOCKED && $stable(ERR_CAPT_ADDR)) else $error("lock lost");
  cover property (FENCE_DONE && ICACHE_FLUSH);
  cover property (OUTST_CNT == OUTST_MAX);
  cover property (LD_ERR && ST_ERR && !ERR_LOCKED);
endmodule : lfg_guard_chk
bind lfg_guard lfg_guard_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .FENCE_REQ(FENCE_REQ),
  .FENCE_STALL(FENCE_STALL), .FENCE_DONE(FENCE_DONE), .ICACHE_FLUSH(ICACHE_FLUSH),
  .RD_BUF_CLEAR(RD_BUF_CLEAR), .ST_BUF_EMPTY(ST_BUF_EMPTY), .WR_BUF_EMPTY(WR_BUF_EMPTY),
  .BUS_REQ_IN(BUS_REQ_IN), .BUS_RSP(BUS_RSP), .OUTST_CNT(OUTST_CNT),
  .BARRIER_DONE(BARRIER_DONE), .ST_ERR(ST_ERR), .LD_ERR(LD_ERR), .LD_ERR_ADDR(LD_ERR_ADDR),
  .ERR_UNLOCK(ERR_UNLOCK), .NMI_REQ(NMI_REQ), .NMI_MCAUSE(NMI_MCAUSE),
  .ERR_CAPT_ADDR(ERR_CAPT_ADDR), .ERR_LOCKED(ERR_LOCKED));
`default_nettype wire

// File: verification/tb.sv
/*
  Self-checking bench for lfg_guard with a bus far-side model.
  Assumes one 20 MHz clock; inputs change 5 ns after rising edges.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, SYS_RST, FENCE_REQ, FENCE_I_REQ, LSU_PIPE_EMPTY, RD_BUF_CLEAR, ST_BUF_EMPTY;
  logic WR_BUF_EMPTY, BUS_REQ_IN, BUS_RSP, ST_ERR, LD_ERR, ERR_UNLOCK, EXT_NMI, FETCH_VALID;
  logic LS_VALID, CORR_INT_EN, hold, FENCE_STALL, FENCE_DONE, ICACHE_FLUSH, BUS_REQ_OK;
  logic BARRIER_DONE, NMI_REQ, ERR_LOCKED, FETCH_FAULT, FETCH_TO_BUS, LS_FAULT, LS_TO_BUS;
  logic CORR_INT_PEND;
  logic [2:0] CERR_EVT, CERR_CLR;
  logic [7:0] OUTST_CNT;
  logic [31:0] ST_ERR_ADDR, LD_ERR_ADDR, FETCH_ADDR, FETCH_LAST, LS_ADDR, LS_LAST;
  logic [31:0] NMI_MCAUSE, ERR_CAPT_ADDR, MTVAL, CORR_MCAUSE;
  logic [47:0] CERR_THRESH;
  int errors, checks;
  lfg_guard #(.I_WIN_EN(8'h01), .I_WIN_MASK(256'h0FFF),
    .D_WIN_EN(8'h01), .D_WIN_BASE(256'h3000_0000), .D_WIN_MASK(256'h003F)) dut (
    .CLK(CLK), .SYS_RST(SYS_RST), .FENCE_REQ(FENCE_REQ), .FENCE_I_REQ(FENCE_I_REQ),
    .LSU_PIPE_EMPTY(LSU_PIPE_EMPTY), .RD_BUF_CLEAR(RD_BUF_CLEAR),
    .ST_BUF_EMPTY(ST_BUF_EMPTY), .WR_BUF_EMPTY(WR_BUF_EMPTY), .FENCE_STALL(FENCE_STALL),
    .FENCE_DONE(FENCE_DONE), .ICACHE_FLUSH(ICACHE_FLUSH), .BUS_REQ_IN(BUS_REQ_IN),
    .BUS_REQ_OK(BUS_REQ_OK), .BUS_RSP(BUS_RSP), .OUTST_CNT(OUTST_CNT),
    .BARRIER_DONE(BARRIER_DONE), .ST_ERR(ST_ERR), .ST_ERR_ADDR(ST_ERR_ADDR),
    .LD_ERR(LD_ERR), .LD_ERR_ADDR(LD_ERR_ADDR), .ERR_UNLOCK(ERR_UNLOCK), .EXT_NMI(EXT_NMI),
    .NMI_REQ(NMI_REQ), .NMI_MCAUSE(NMI_MCAUSE), .ERR_CAPT_ADDR(ERR_CAPT_ADDR),
    .ERR_LOCKED(ERR_LOCKED), .FETCH_VALID(FETCH_VALID), .FETCH_ADDR(FETCH_ADDR),
    .FETCH_LAST(FETCH_LAST), .FETCH_FAULT(FETCH_FAULT), .FETCH_TO_BUS(FETCH_TO_BUS),
    .LS_VALID(LS_VALID), .LS_ADDR(LS_ADDR), .LS_LAST(LS_LAST), .LS_FAULT(LS_FAULT),
    .LS_TO_BUS(LS_TO_BUS), .MTVAL(MTVAL), .CERR_EVT(CERR_EVT), .CERR_CLR(CERR_CLR),
    .CERR_THRESH(CERR_THRESH), .CORR_INT_EN(CORR_INT_EN), .CORR_INT_PEND(CORR_INT_PEND),
    .CORR_MCAUSE(CORR_MCAUSE));
  lfg_bus_model bus (.clk(CLK), .rst(SYS_RST), .req(BUS_REQ_IN),
    .acc_ok(OUTST_CNT != 8'hFF), .hold(hold), .rsp(BUS_RSP));
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #5;
  endtask : tick
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic wait_done();
    int n;
    n = 0;
    while (FENCE_DONE !== 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
  endtask : wait_done
  // One access, answer one edge later, valid dropped before the next call
  task automatic acc(input logic ls, input logic [31:0] a, input logic [31:0] l,
    input logic f, input logic b);
    {LS_VALID, FETCH_VALID} = {ls, !ls};
    {LS_ADDR, LS_LAST, FETCH_ADDR, FETCH_LAST} = {a, l, a, l};
    tick(1);
    chk(ls ? LS_FAULT : FETCH_FAULT, f);
    chk(ls ? LS_TO_BUS : FETCH_TO_BUS, b);
    if (f)
      chk(MTVAL, a);
    {LS_VALID, FETCH_VALID} = 2'b00;
    tick(1);
  endtask : acc
  initial
  begin
    #200000;
    errors++;
    close_out();
  end
  initial
  begin
    {errors, checks} = '0;
    {FENCE_REQ, FENCE_I_REQ, LSU_PIPE_EMPTY, RD_BUF_CLEAR, ST_BUF_EMPTY, WR_BUF_EMPTY} = '0;
    {BUS_REQ_IN, ST_ERR, LD_ERR, ERR_UNLOCK, EXT_NMI, FETCH_VALID, LS_VALID, hold} = '0;
    {CORR_INT_EN, CERR_EVT, CERR_CLR, ST_ERR_ADDR, LD_ERR_ADDR} = '0;
    {FETCH_ADDR, FETCH_LAST, LS_ADDR, LS_LAST} = '0;
    CERR_THRESH = {16'hFFFF, 16'hFFFF, 16'h0002};
    SYS_RST = 1'b1;
    tick(3);
    SYS_RST = 1'b0;
    chk(BARRIER_DONE, 1);
    chk(CORR_MCAUSE, 32'h8000_001E);
    {hold, BUS_REQ_IN} = 2'b11;
    tick(3);
    chk(OUTST_CNT, 3);
    chk(BARRIER_DONE, 0);
    tick(260);
    chk(OUTST_CNT, 8'hFF);
    chk(BUS_REQ_OK, 0);
    {BUS_REQ_IN, FENCE_REQ} = 2'b01;
    tick(1);
    FENCE_REQ = 1'b0;
    tick(4);
    chk(FENCE_STALL, 1);
    {LSU_PIPE_EMPTY, RD_BUF_CLEAR, ST_BUF_EMPTY, WR_BUF_EMPTY} = 4'hF;
    tick(4);
    chk(FENCE_STALL, 1);
    hold = 1'b0;
    wait_done();
    chk(FENCE_DONE, 1);
    chk(OUTST_CNT, 0);
    chk(ICACHE_FLUSH, 0);
    tick(1);
    {LSU_PIPE_EMPTY, FENCE_I_REQ} = 2'b01;
    tick(1);
    FENCE_I_REQ = 1'b0;
    tick(3);
    chk(FENCE_STALL, 1);
    LSU_PIPE_EMPTY = 1'b1;
    wait_done();
    chk(ICACHE_FLUSH, 1);
    {LD_ERR, ST_ERR, LD_ERR_ADDR, ST_ERR_ADDR} = {2'b11, 32'h4000_0010, 32'h4000_0020};
    tick(1);
    {LD_ERR, ST_ERR} = 2'b00;
    chk(NMI_MCAUSE, 32'hF000_0001);
    chk(ERR_CAPT_ADDR, 32'h4000_0010);
    tick(1);
    chk(NMI_REQ, 1);
    {ST_ERR, ST_ERR_ADDR} = {1'b1, 32'h4000_0030};
    tick(1);
    ST_ERR = 1'b0;
    tick(1);
    chk(ERR_CAPT_ADDR, 32'h4000_0010);
    chk(ERR_LOCKED, 1);
    ERR_UNLOCK = 1'b1;
    tick(1);
    ERR_UNLOCK = 1'b0;
    chk(ERR_LOCKED, 0);
    ST_ERR = 1'b1;
    tick(1);
    ST_ERR = 1'b0;
    chk(NMI_MCAUSE, 32'hF000_0000);
    chk(ERR_CAPT_ADDR, 32'h4000_0030);
    acc(0, 32'h0000_0010, 32'h0000_0013, 0, 1);
    acc(0, 32'h0000_1000, 32'h0000_1003, 1, 0);
    acc(0, 32'hF000_0100, 32'hF000_0103, 0, 0);
    acc(0, 32'hF000_FFFE, 32'hF001_0001, 1, 0);
    acc(0, 32'hF00C_0000, 32'hF00C_0003, 1, 0);
    acc(1, 32'h3000_0000, 32'h3000_0003, 0, 1);
    acc(1, 32'h3000_0040, 32'h3000_0043, 1, 0);
    acc(1, 32'hF00C_0000, 32'hF00C_0003, 0, 0);
    acc(1, 32'hF000_FFFC, 32'hF001_0003, 1, 0);
    CORR_INT_EN = 1'b1;
    repeat (2)
    begin
      chk(CORR_INT_PEND, 0);
      CERR_EVT = 3'b001;
      tick(1);
      CERR_EVT = 3'b000;
      tick(2);
    end
    chk(CORR_INT_PEND, 1);
    CORR_INT_EN = 1'b0;
    tick(2);
    chk(CORR_INT_PEND, 0);
    {CORR_INT_EN, CERR_CLR} = 4'b1001;
    tick(1);
    CERR_CLR = 3'b000;
    tick(2);
    chk(CORR_INT_PEND, 0);
    SYS_RST = 1'b1;
    tick(2);
    SYS_RST = 1'b0;
    chk(ERR_LOCKED, 0);
    chk(NMI_REQ, 0);
    EXT_NMI = 1'b1;
    tick(5);
    chk(NMI_REQ, 1);
    EXT_NMI = 1'b0;
    tick(5);
    chk(NMI_REQ, 0);
    close_out();
  end
endmodule : tb
`default_nettype wire
